// ---- design/ppe_parallel_port.sv ----
// Parallel port with compatible, bidirectional and enhanced transfer modes.
// Assumes a host I/O front end that issues one request and waits for rdy;
// all pin inputs are synchronous to clk.
`timescale 1ns/1ps

module ppe_parallel_port (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Configuration
  input wire ppe_pkg::ppe_mode_t mode,
  input wire logic timeout_select,
  // Host I/O
  input wire ppe_pkg::ppe_host_req_t host_req,
  output ppe_pkg::ppe_host_rsp_t host_rsp,
  // Parallel cable
  input wire ppe_pkg::ppe_pin_in_t pin_in,
  output ppe_pkg::ppe_pin_out_t pin_out,
  // Interrupt
  output logic irq
);

  ppe_pkg::ppe_port_state_t st_q, st_d;
  logic [7:0] status_now;
  logic take;
  logic wd_start;
  logic wd_run;
  logic wd_expired;
  logic epp_drive;
  logic strobe_on;

  // ----------------------------------------
  // Watchdog
  // ----------------------------------------
  // guard enhanced cycle
  assign wd_run = (st_q.state == ppe_pkg::S_SYNC) || (st_q.state == ppe_pkg::S_SETUP) ||
                  (st_q.state == ppe_pkg::S_STB);

  ppe_watchdog u_wdog (
    .clk(clk),
    .resetn(resetn),
    .start(wd_start),
    .run(wd_run),
    .expired(wd_expired)
  );

  // ----------------------------------------
  // Status byte
  // ----------------------------------------
  always_comb begin
    status_now = 8'h00;
    status_now[ppe_pkg::ST_BUS_TIMEOUT_FLAG] = st_q.bus_timeout_flag;
    status_now[ppe_pkg::ST_FAULT] = pin_in.fault_n;
    status_now[ppe_pkg::ST_ONLINE] = pin_in.printer_online_input;
    status_now[ppe_pkg::ST_PAPER] = pin_in.paper_out_input;
    status_now[ppe_pkg::ST_ACK] = pin_in.ack;
    status_now[ppe_pkg::ST_READY] = ~pin_in.busy_line;
  end

  assign take = (st_q.state == ppe_pkg::S_IDLE) && host_req.req;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.rsp.rdy = 1'b0;
    st_d.irq = 1'b0;
    st_d.ack_prev = pin_in.ack;
    wd_start = 1'b0;
    epp_drive = 1'b0;
    strobe_on = 1'b0;

    if (st_q.ctrl[ppe_pkg::CT_PORT_IRQ_ENABLE] && pin_in.ack && !st_q.ack_prev) begin
      st_d.irq = 1'b1;
    end

    case (st_q.state)
      ppe_pkg::S_IDLE: begin
        if (host_req.req) begin
          st_d.addr = host_req.addr;
          if (host_req.addr >= ppe_pkg::ADDR_EPP_ADDR) begin
            if (mode == ppe_pkg::MODE_EPP) begin
              st_d.state = ppe_pkg::S_SYNC;
              st_d.rsp.busy = 1'b1;
              wd_start = 1'b1;
              // direction bit turns write to read
              st_d.wrcyc = st_q.ctrl[ppe_pkg::CT_STROBE] |
                           (host_req.wr & ~st_q.ctrl[ppe_pkg::CT_DIR]);
              if (host_req.wr) begin
                st_d.abyte = host_req.wdata;
              end
            end else begin
              st_d.rsp.rdy = 1'b1;
              st_d.rsp.rdata = ppe_pkg::UNMAPPED_RD;
            end
          end else begin
            st_d.rsp.rdy = 1'b1;
            st_d.rsp.rdata = 8'h00;
            case (host_req.addr)
              ppe_pkg::ADDR_DATA: begin
                if (host_req.wr) begin
                  st_d.odata = host_req.wdata;
                end
                st_d.rsp.rdata = pin_in.data;
              end
              ppe_pkg::ADDR_STATUS: begin
                st_d.rsp.rdata = status_now;
                // clear by write one or by read
                if (host_req.wr && !timeout_select && host_req.wdata[ppe_pkg::ST_BUS_TIMEOUT_FLAG]) begin
                  st_d.bus_timeout_flag = 1'b0;
                end
                if (!host_req.wr && timeout_select) begin
                  st_d.bus_timeout_flag = 1'b0;
                end
              end
              default: begin
                if (host_req.wr) begin
                  st_d.ctrl = host_req.wdata[ppe_pkg::CT_W-1:0];
                end
                st_d.rsp.rdata = {ppe_pkg::CTRL_HI_ZERO, st_q.ctrl};
              end
            endcase
          end
        end
      end
      ppe_pkg::S_SYNC: begin
        // wait for hold active before moving lines
        if (!pin_in.busy_line) begin
          st_d.state = ppe_pkg::S_SETUP;
        end
      end
      ppe_pkg::S_SETUP: begin
        st_d.state = ppe_pkg::S_STB;
      end
      ppe_pkg::S_STB: begin
        if (pin_in.busy_line) begin
          st_d.state = ppe_pkg::S_END;
          st_d.rsp.rdy = 1'b1;
          st_d.rsp.busy = 1'b0;
          st_d.rsp.rdata = pin_in.data;
        end
      end
      ppe_pkg::S_END: begin
        st_d.state = ppe_pkg::S_IDLE;
      end
      default: begin
        st_d.state = ppe_pkg::S_IDLE;
      end
    endcase

    // abort and flag; set wins over a clear
    if (wd_expired && wd_run) begin
      st_d.bus_timeout_flag = 1'b1;
      st_d.state = ppe_pkg::S_END;
      st_d.rsp.rdy = 1'b1;
      st_d.rsp.busy = 1'b0;
      st_d.rsp.rdata = pin_in.data;
    end

    // ----------------------------------------
    // Pin drive
    // ----------------------------------------
    // Lines stay on the control register until hold is seen active or the watchdog aborts the cycle
    epp_drive = (st_d.state == ppe_pkg::S_SETUP) || (st_d.state == ppe_pkg::S_STB) ||
                (st_d.state == ppe_pkg::S_END);
    strobe_on = (st_d.state == ppe_pkg::S_STB);
    st_d.pout.init_pin = st_d.ctrl[ppe_pkg::CT_INIT];
    if (epp_drive) begin
      // byte and direction ahead of strobe
      st_d.pout.data = st_d.abyte;
      st_d.pout.data_oe = st_d.wrcyc;
      st_d.pout.strobe_pin_n = ~st_d.wrcyc;
      st_d.pout.printer_choose_pin_n = ~(strobe_on && st_d.addr == ppe_pkg::ADDR_EPP_ADDR);
      // data strobe on offsets 4 to 7
      st_d.pout.line_feed_request_pin_n = ~(strobe_on && st_d.addr != ppe_pkg::ADDR_EPP_ADDR);
    end else begin
      st_d.pout.data = st_d.odata;
      // direction bit, forced out in compatible mode
      st_d.pout.data_oe = (mode == ppe_pkg::MODE_SPP) | ~st_d.ctrl[ppe_pkg::CT_DIR];
      st_d.pout.strobe_pin_n = ~st_d.ctrl[ppe_pkg::CT_STROBE];
      st_d.pout.line_feed_request_pin_n = ~st_d.ctrl[ppe_pkg::CT_FEED];
      st_d.pout.printer_choose_pin_n = ~st_d.ctrl[ppe_pkg::CT_CHOOSE];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
      st_q.odata <= ppe_pkg::ODATA_RST;
      st_q.ctrl <= ppe_pkg::CTRL_RST;
      st_q.pout <= ppe_pkg::PIN_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign host_rsp = st_q.rsp;
  assign pin_out = st_q.pout;
  assign irq = st_q.irq;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  property p_data_write;
    take && host_req.wr && host_req.addr == ppe_pkg::ADDR_DATA
      |=> st_q.odata == $past(host_req.wdata) && st_q.rsp.rdy;
  endproperty
  a_data_write: assert property (p_data_write) else $error("data write not stored");

  property p_status_read;
    take && !host_req.wr && host_req.addr == ppe_pkg::ADDR_STATUS
      |=> st_q.rsp.rdy && st_q.rsp.rdata[7:3] == $past({~pin_in.busy_line, pin_in.ack,
          pin_in.paper_out_input, pin_in.printer_online_input, pin_in.fault_n});
  endproperty
  a_status_read: assert property (p_status_read) else $error("status inputs wrong");

  property p_status_ready;
    take && !host_req.wr && host_req.addr == ppe_pkg::ADDR_STATUS
      |=> st_q.rsp.rdata[ppe_pkg::ST_READY] != $past(pin_in.busy_line);
  endproperty
  a_status_ready: assert property (p_status_ready) else $error("ready bit not inverted");

  property p_status_zero;
    take && host_req.addr == ppe_pkg::ADDR_STATUS
      |=> st_q.rsp.rdata[ppe_pkg::ST_RSV_HI:ppe_pkg::ST_RSV_LO] == 2'h0;
  endproperty
  a_status_zero: assert property (p_status_zero) else $error("status bits 1-2 not zero");

  property p_ctrl_high;
    take && host_req.addr == ppe_pkg::ADDR_CTRL |=> st_q.rsp.rdata[7:6] == 2'h0;
  endproperty
  a_ctrl_high: assert property (p_ctrl_high) else $error("control bits 6-7 not zero");

  property p_bus_timeout_flag_clear;
    take && host_req.wr && host_req.addr == ppe_pkg::ADDR_STATUS && !timeout_select &&
      host_req.wdata[ppe_pkg::ST_BUS_TIMEOUT_FLAG] |=> !st_q.bus_timeout_flag;
  endproperty
  a_bus_timeout_flag_clear: assert property (p_bus_timeout_flag_clear) else $error("timeout flag not cleared");

  property p_idle_pins;
    st_q.state == ppe_pkg::S_IDLE |-> pin_out.strobe_pin_n == ~st_q.ctrl[ppe_pkg::CT_STROBE] &&
      pin_out.init_pin == st_q.ctrl[ppe_pkg::CT_INIT] &&
      pin_out.printer_choose_pin_n == ~st_q.ctrl[ppe_pkg::CT_CHOOSE];
  endproperty
  a_idle_pins: assert property (p_idle_pins) else $error("control pins mismatch");

  property p_irq;
    st_q.ctrl[ppe_pkg::CT_PORT_IRQ_ENABLE] && $rose(pin_in.ack) |=> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missed");

  property p_timeout;
    wd_expired && wd_run |=> st_q.bus_timeout_flag && st_q.rsp.rdy && st_q.state == ppe_pkg::S_END;
  endproperty
  a_timeout: assert property (p_timeout) else $error("timeout not flagged");

  property p_hold_first;
    st_q.state == ppe_pkg::S_SYNC |-> pin_out.line_feed_request_pin_n &&
      pin_out.printer_choose_pin_n;
  endproperty
  a_hold_first: assert property (p_hold_first) else $error("strobe before hold");

  property p_setup_order;
    $fell(pin_out.line_feed_request_pin_n && pin_out.printer_choose_pin_n) && st_q.wrcyc &&
      st_q.state == ppe_pkg::S_STB
      |-> $past(pin_out.data_oe) && !$past(pin_out.strobe_pin_n);
  endproperty
  a_setup_order: assert property (p_setup_order) else $error("strobe before setup");

  property p_write_as_read;
    take && host_req.wr && host_req.addr >= ppe_pkg::ADDR_EPP_ADDR &&
      mode == ppe_pkg::MODE_EPP && st_q.ctrl[ppe_pkg::CT_DIR] &&
      !st_q.ctrl[ppe_pkg::CT_STROBE] |=> !st_q.wrcyc ##2 !pin_out.data_oe;
  endproperty
  a_write_as_read: assert property (p_write_as_read) else $error("write not turned to read");

  c_epp_write: cover property (st_q.state == ppe_pkg::S_END && st_q.wrcyc && !st_q.bus_timeout_flag);
  c_epp_read: cover property (st_q.state == ppe_pkg::S_END && !st_q.wrcyc);
  c_timeout: cover property (wd_expired && wd_run);
  c_irq: cover property (irq);

endmodule

// ---- design/ppe_pkg.sv ----
// Constants, types and register map of the parallel port with enhanced cycles.
// Assumes one 40 MHz core clock and a host I/O decoder that hands over
// one byte-wide request at a time and waits for the ready answer.
// How it works
// - Data register resets, stores writes, drives pins
// - Compatible mode data read returns live pins
// - Status byte held stable for each read
// - Timeout flag set, cleared by write or read
// - Status bits 1 and 2 read zero
// - Status bits 3 to 6 mirror inputs
// - Status bit 7 is inverted busy
// - Control bits 6, 7 read zero, unwritable
// - Control bits drive strobe, feed, init, choose
// - Enabled acknowledge rising edge raises interrupt
// - Direction bit steers pins except compatible mode
// - Offset 3 runs address write or read
// - Offsets 4 to 7 run data cycles
// - Enhanced ports only in enhanced mode
// - Watchdog aborts cycle, sets timeout flag
// - Active strobe bit forces write direction
// - Write with direction set becomes read
// - Stretch host cycle, wait for hold first
// - Data and direction before address/data strobe
// - Hold release ends strobe and host cycle
// - Interrupt input passes uninverted, rising edge

package ppe_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_STATUS = 3'h1;
  localparam logic [2:0] ADDR_CTRL = 3'h2;
  localparam logic [2:0] ADDR_EPP_ADDR = 3'h3;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int ST_BUS_TIMEOUT_FLAG = 0;
  localparam int ST_RSV_LO = 1;
  localparam int ST_RSV_HI = 2;
  localparam int ST_FAULT = 3;
  localparam int ST_ONLINE = 4;
  localparam int ST_PAPER = 5;
  localparam int ST_ACK = 6;
  localparam int ST_READY = 7;
  localparam int CT_STROBE = 0;
  localparam int CT_FEED = 1;
  localparam int CT_INIT = 2;
  localparam int CT_CHOOSE = 3;
  localparam int CT_PORT_IRQ_ENABLE = 4;
  localparam int CT_DIR = 5;
  localparam int CT_W = 6;

  // ----------------------------------------
  // Reset and fixed values
  // ----------------------------------------
  localparam logic [7:0] ODATA_RST = 8'h00;
  localparam logic [5:0] CTRL_RST = 6'h00;
  localparam logic [7:0] UNMAPPED_RD = 8'hFF;
  localparam logic [1:0] CTRL_HI_ZERO = 2'h0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int TMO_US = 10;
  localparam int WDOG_CYC = (TMO_US * 1000) / CLK_PERIOD_NS;
  localparam int WDOG_W = 9;
  localparam logic [WDOG_W-1:0] WDOG_LIM = WDOG_W'(WDOG_CYC);

  // ----------------------------------------
  // Modes and states
  // ----------------------------------------
  typedef enum logic [1:0] {MODE_SPP, MODE_BIDIR, MODE_EPP} ppe_mode_t;
  typedef enum logic [2:0] {S_IDLE, S_SYNC, S_SETUP, S_STB, S_END} ppe_epp_state_t;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic req;
    logic wr;
    logic [2:0] addr;
    logic [7:0] wdata;
  } ppe_host_req_t;

  typedef struct packed {
    logic rdy;
    logic busy;
    logic [7:0] rdata;
  } ppe_host_rsp_t;

  // Busy line doubles as the peripheral_hold_n line in enhanced cycles
  typedef struct packed {
    logic [7:0] data;
    logic ack;
    logic busy_line;
    logic paper_out_input;
    logic printer_online_input;
    logic fault_n;
  } ppe_pin_in_t;

  // In enhanced cycles: strobe pin is transfer_dir_n, feed pin is
  // data_phase_stb_n, choose pin is addr_phase_stb_n
  typedef struct packed {
    logic [7:0] data;
    logic data_oe;
    logic strobe_pin_n;
    logic line_feed_request_pin_n;
    logic init_pin;
    logic printer_choose_pin_n;
  } ppe_pin_out_t;

  localparam ppe_pin_out_t PIN_RST = '{data: 8'h00, data_oe: 1'b1, strobe_pin_n: 1'b1,
    line_feed_request_pin_n: 1'b1, init_pin: 1'b0, printer_choose_pin_n: 1'b1};

  typedef struct packed {
    ppe_epp_state_t state;
    logic [7:0] odata;
    logic [CT_W-1:0] ctrl;
    logic bus_timeout_flag;
    logic ack_prev;
    logic wrcyc;
    logic [2:0] addr;
    logic [7:0] abyte;
    ppe_host_rsp_t rsp;
    ppe_pin_out_t pout;
    logic irq;
  } ppe_port_state_t;

  typedef struct packed {
    logic [WDOG_W-1:0] cnt;
    logic expired;
  } ppe_wdog_state_t;

endpackage

// ---- design/ppe_watchdog.sv ----
// Cycle watchdog for enhanced transfers.
// Assumes start pulses once as a cycle begins and run stays high while it lasts.
`timescale 1ns/1ps

module ppe_watchdog (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Control
  input wire logic start,
  input wire logic run,
  // Result
  output logic expired
);

  ppe_pkg::ppe_wdog_state_t st_q, st_d;

  // ----------------------------------------
  // Counter
  // ----------------------------------------
  always_comb begin
    st_d = st_q;
    st_d.expired = 1'b0;
    if (start) begin
      st_d.cnt = '0;
    end else if (run && st_q.cnt != ppe_pkg::WDOG_LIM) begin
      st_d.cnt = st_q.cnt + 1'b1;
      // Fires once; the counter then parks until the next start
      st_d.expired = (st_d.cnt == ppe_pkg::WDOG_LIM);
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign expired = st_q.expired;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_wdog_bound;
    @(posedge clk) disable iff (!resetn)
    st_q.cnt <= ppe_pkg::WDOG_LIM && (!st_q.expired || st_q.cnt == ppe_pkg::WDOG_LIM);
  endproperty
  a_wdog_bound: assert property (p_wdog_bound) else $error("watchdog count out of range");

endmodule

// ---- tb/ppe_parallel_port_tb.sv ----
// Self-checking bench for the parallel port with enhanced cycles.
// Assumes the peripheral model and the design package are compiled first.
`timescale 1ns/1ps

module ppe_parallel_port_tb;
  logic clk;
  logic resetn;
  ppe_pkg::ppe_mode_t mode;
  logic timeout_select;
  ppe_pkg::ppe_host_req_t host_req;
  ppe_pkg::ppe_host_rsp_t host_rsp;
  ppe_pkg::ppe_pin_in_t pin_in;
  ppe_pkg::ppe_pin_out_t pin_out;
  logic irq;
  logic [3:0] hold_delay;
  logic stuck;
  logic ext_en;
  logic [7:0] ext_byte;
  logic [7:0] rd_byte;
  logic hold_n;
  logic [7:0] pdata;
  logic [7:0] got_byte;
  logic got_addr;
  logic got_dir_n;
  logic ack;
  logic spp_busy;
  logic paper;
  logic online;
  logic fault_n;
  logic busy_seen;
  logic [7:0] rd;
  int n_mismatch;
  int checked;
  int lat;
  int irq_cnt;

  // ----------------------------------------
  // Instances
  // ----------------------------------------
  assign pin_in = '{data: pdata, ack: ack,
    busy_line: (mode == ppe_pkg::MODE_EPP) ? (hold_n | spp_busy) : spp_busy,
    paper_out_input: paper, printer_online_input: online, fault_n: fault_n};

  ppe_parallel_port dut (.clk(clk), .resetn(resetn), .mode(mode),
    .timeout_select(timeout_select), .host_req(host_req), .host_rsp(host_rsp),
    .pin_in(pin_in), .pin_out(pin_out), .irq(irq));

  ppe_periph_model pm (.clk(clk), .resetn(resetn), .pin_out(pin_out),
    .hold_delay(hold_delay), .stuck(stuck), .ext_en(ext_en), .ext_byte(ext_byte),
    .rd_byte(rd_byte), .hold_n(hold_n), .pdata(pdata), .got_byte(got_byte),
    .got_addr(got_addr), .got_dir_n(got_dir_n));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Request is a one-cycle pulse; held longer it would be taken again
  task automatic acc(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(negedge clk);
    host_req = '{req: 1'b1, wr: w, addr: a, wdata: d};
    @(negedge clk);
    host_req.req = 1'b0;
    lat = 1;
    busy_seen = 1'b0;
    while (host_rsp.rdy !== 1'b1 && lat < 600) begin
      busy_seen = busy_seen | (host_rsp.busy === 1'b1);
      @(negedge clk);
      lat++;
    end
    rd = host_rsp.rdata;
    chk({7'h00, host_rsp.rdy}, 8'h01);
    // Pins and hold settle one cycle after an enhanced answer
    if (busy_seen) begin
      @(negedge clk);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    acc(1'b1, a, d);
  endtask

  task automatic rdc(input logic [2:0] a, input logic [7:0] exp);
    acc(1'b0, a, 8'h00);
    chk(rd, exp);
  endtask

  function automatic logic [7:0] stexp(input logic t);
    return {~((mode == ppe_pkg::MODE_EPP) ? (hold_n | spp_busy) : spp_busy), ack, paper, online,
      fault_n, 2'h0, t};
  endfunction

  task automatic ack_edge(input logic [7:0] exp);
    int n0;
    ack = 1'b0;
    repeat (2) @(negedge clk);
    n0 = irq_cnt;
    ack = 1'b1;
    repeat (3) @(negedge clk);
    chk(8'(irq_cnt - n0), exp);
  endtask

  always @(negedge clk) begin
    if (irq === 1'b1) begin
      irq_cnt++;
    end
  end

  // ----------------------------------------
  // Clock and watchdog
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Tests need about 1000 cycles; this allows twenty times that
  initial begin
    #500000;
    n_mismatch++;
    tally_and_finish();
  end

  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    resetn = 1'b0;
    mode = ppe_pkg::MODE_SPP;
    timeout_select = 1'b0;
    host_req = '0;
    {hold_delay, stuck, ext_en, ext_byte, rd_byte} = '0;
    {ack, spp_busy, paper, online, fault_n} = 5'h01;
    n_mismatch = 0;
    checked = 0;
    irq_cnt = 0;
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    chk({4'h0, pin_out.strobe_pin_n, pin_out.line_feed_request_pin_n, pin_out.init_pin,
      pin_out.printer_choose_pin_n}, 8'h0D);
    rdc(ppe_pkg::ADDR_DATA, 8'h00);
    rdc(ppe_pkg::ADDR_CTRL, 8'h00);
    wr(ppe_pkg::ADDR_DATA, 8'hA5);
    chk(pin_out.data, 8'hA5);
    rdc(ppe_pkg::ADDR_DATA, 8'hA5);
    for (int i = 0; i < 2; i++) begin
      {spp_busy, ack, paper, online, fault_n} = (i == 0) ? 5'h15 : 5'h0A;
      rdc(ppe_pkg::ADDR_STATUS, stexp(1'b0));
    end
    wr(ppe_pkg::ADDR_CTRL, 8'hFF);
    rdc(ppe_pkg::ADDR_CTRL, 8'h3F);
    chk({3'h0, pin_out.data_oe, pin_out.strobe_pin_n, pin_out.line_feed_request_pin_n,
      pin_out.init_pin, pin_out.printer_choose_pin_n}, 8'h12);
    mode = ppe_pkg::MODE_BIDIR;
    ext_en = 1'b1;
    ext_byte = 8'h3C;
    wr(ppe_pkg::ADDR_CTRL, 8'h20);
    chk({7'h00, pin_out.data_oe}, 8'h00);
    rdc(ppe_pkg::ADDR_DATA, 8'h3C);
    wr(3'h4, 8'h77);
    chk(8'(lat), 8'h01);
    rdc(ppe_pkg::ADDR_EPP_ADDR, 8'hFF);
    wr(ppe_pkg::ADDR_CTRL, 8'h10);
    ack_edge(8'h01);
    wr(ppe_pkg::ADDR_CTRL, 8'h00);
    ack_edge(8'h00);
    mode = ppe_pkg::MODE_EPP;
    ext_en = 1'b0;
    wr(ppe_pkg::ADDR_CTRL, 8'h04);
    for (int a = 3; a < 8; a++) begin
      hold_delay = 4'(a);
      wr(3'(a), 8'h30 + 8'(a));
      chk(got_byte, 8'h30 + 8'(a));
      chk({5'h00, busy_seen, got_addr, got_dir_n}, {5'h00, 1'b1, (a == 3), 1'b0});
      rd_byte = 8'hC0 + 8'(a);
      rdc(3'(a), 8'hC0 + 8'(a));
      chk({6'h00, got_addr, got_dir_n}, {6'h00, (a == 3), 1'b1});
      chk({7'h00, pin_out.data_oe}, 8'h01);
    end
    // Busy override keeps hold inactive at the start; no line may move until it drops
    spp_busy = 1'b1;
    fork
      wr(3'h6, 8'h4E);
      begin
        repeat (4) @(negedge clk);
        chk({6'h00, pin_out.strobe_pin_n, pin_out.line_feed_request_pin_n}, 8'h03);
        spp_busy = 1'b0;
      end
    join
    chk(got_byte, 8'h4E);
    chk(8'(lat >= 6), 8'h01);
    wr(ppe_pkg::ADDR_CTRL, 8'h24);
    wr(3'h4, 8'h5A);
    chk({7'h00, got_dir_n}, 8'h01);
    rdc(ppe_pkg::ADDR_STATUS, stexp(1'b0));
    wr(ppe_pkg::ADDR_CTRL, 8'h25);
    wr(3'h5, 8'h66);
    chk({got_dir_n, got_byte[6:0]}, 8'h66);
    wr(ppe_pkg::ADDR_CTRL, 8'h04);
    stuck = 1'b1;
    for (int s = 0; s < 2; s++) begin
      timeout_select = 1'(s);
      wr(3'h4, 8'h11);
      chk(8'(lat >= 400 && lat <= 410), 8'h01);
      rdc(ppe_pkg::ADDR_STATUS, stexp(1'b1));
      if (s == 0) begin
        wr(ppe_pkg::ADDR_STATUS, 8'h00);
        rdc(ppe_pkg::ADDR_STATUS, stexp(1'b1));
        wr(ppe_pkg::ADDR_STATUS, 8'h01);
      end
      rdc(ppe_pkg::ADDR_STATUS, stexp(1'b0));
    end
    tally_and_finish();
  end
endmodule

// ---- tb/ppe_periph_model.sv ----
// Behavioural peripheral on the parallel cable, answering enhanced cycles.
// Assumes the port's pin outputs are registered on the same clock.
`timescale 1ns/1ps

module ppe_periph_model (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Port pins
  input wire ppe_pkg::ppe_pin_out_t pin_out,
  // Bench commands
  input wire logic [3:0] hold_delay,
  input wire logic stuck,
  input wire logic ext_en,
  input wire logic [7:0] ext_byte,
  input wire logic [7:0] rd_byte,
  // Cable levels and observations
  output logic hold_n,
  output logic [7:0] pdata,
  output logic [7:0] got_byte,
  output logic got_addr,
  output logic got_dir_n
);
  logic stb;
  logic drv;
  logic [3:0] cnt;
  logic [7:0] last;

  assign stb = !pin_out.line_feed_request_pin_n || !pin_out.printer_choose_pin_n;
  assign drv = stb && pin_out.strobe_pin_n && !pin_out.data_oe;
  // Released lines flip each cycle so a stale value never looks valid
  assign pdata = pin_out.data_oe ? pin_out.data : drv ? rd_byte : ext_en ? ext_byte : ~last;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hold_n <= 1'b0;
      cnt <= 4'h0;
      last <= 8'h00;
      got_byte <= 8'h00;
      got_addr <= 1'b0;
      got_dir_n <= 1'b1;
    end else begin
      last <= pdata;
      if (stb) begin
        // latch byte, release hold after setup
        got_byte <= pdata;
        got_addr <= !pin_out.printer_choose_pin_n;
        got_dir_n <= pin_out.strobe_pin_n;
        if (!stuck && cnt == hold_delay) begin
          hold_n <= 1'b1;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end else begin
        hold_n <= 1'b0;
        cnt <= 4'h0;
      end
    end
  end
endmodule
